// *** src/hbsd_pkg.sv ***
package hbsd_pkg;

    localparam int unsigned INDEX_WIDTH = 3;
    localparam int unsigned DATA_WIDTH  = 8;
    localparam int unsigned SYNC_STAGES = 2;

    localparam logic [DATA_WIDTH-1:0]  DATA_RESET  = 8'h00;
    localparam logic [INDEX_WIDTH-1:0] INDEX_RESET = 3'h0;
    localparam logic                   STYLE_SPLIT  = 1'h0;
    localparam logic                   STYLE_SINGLE = 1'h1;

    // host side pins, raw from the package balls
    typedef struct packed {
        logic                   read_strobe_low;
        logic                   read_strobe_high;
        logic                   write_strobe_low;
        logic                   write_strobe_high;
        logic                   bus_style_select;
        logic                   select_a_high;
        logic                   select_b_high;
        logic                   select_c_low;
        logic [INDEX_WIDTH-1:0] register_index;
        logic [DATA_WIDTH-1:0]  host_data_in;
    } hbsd_pins_type;

    localparam hbsd_pins_type PINS_RESET = '{
        read_strobe_low:   1'h1,
        read_strobe_high:  1'h0,
        write_strobe_low:  1'h1,
        write_strobe_high: 1'h0,
        bus_style_select:  1'h0,
        select_a_high:     1'h0,
        select_b_high:     1'h0,
        select_c_low:      1'h1,
        register_index:    3'h0,
        host_data_in:      8'h00
    };

    // request to the register file behind the port
    typedef struct packed {
        logic                   read_req;
        logic                   write_req;
        logic [INDEX_WIDTH-1:0] index;
        logic [DATA_WIDTH-1:0]  write_data;
    } hbsd_req_type;

    typedef enum logic [1:0] {
        HBSD_IDLE  = 2'b00,
        HBSD_READ  = 2'b01,
        HBSD_WRITE = 2'b10
    } hbsd_state_type;

endpackage : hbsd_pkg

// *** src/hbsd_decode.sv ***
`timescale 1ns/1ns
`default_nettype none
module hbsd_decode (
    // clock and reset
    input  wire logic                           clock,
    input  wire logic                           nrst,
    // host pins, asynchronous to clock
    input  wire hbsd_pkg::hbsd_pins_type        pins,
    // host data bus drive
    output logic [hbsd_pkg::DATA_WIDTH-1:0]     host_data_out,
    output logic                                host_data_oe,
    // register file side
    output hbsd_pkg::hbsd_req_type              req,
    input  wire logic [hbsd_pkg::DATA_WIDTH-1:0] reg_read_data,
    // cycle state
    output hbsd_pkg::hbsd_state_type            cycle_state
);
    import hbsd_pkg::*;

    hbsd_pins_type  pins_meta;
    hbsd_pins_type  pins_sync;
    logic           selected;
    logic           read_active;
    logic           write_active;
    logic           read_pending;
    hbsd_state_type next_state;

    // two-stage synchroniser; strobes and data share the same delay so
    // data captured with a strobe is as old as the strobe itself
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pins_meta <= PINS_RESET;
            pins_sync <= PINS_RESET;
        end else begin
            pins_meta <= pins;
            pins_sync <= pins_meta;
        end
    end

    always_comb begin
        selected = pins_sync.select_a_high & pins_sync.select_b_high & ~pins_sync.select_c_low;
        if (pins_sync.bus_style_select == STYLE_SINGLE) begin
            // read strobes and write-high are not looked at here
            read_active  = selected & pins_sync.write_strobe_low;
            write_active = selected & ~pins_sync.write_strobe_low;
        end else begin
            read_active  = selected & (~pins_sync.read_strobe_low | pins_sync.read_strobe_high);
            write_active = selected & (~pins_sync.write_strobe_low | pins_sync.write_strobe_high);
        end
    end

    always_comb begin
        next_state = cycle_state;
        unique case (cycle_state)
            HBSD_IDLE: begin
                if (read_active) begin
                    next_state = HBSD_READ;
                end else if (write_active) begin
                    next_state = HBSD_WRITE;
                end
            end
            HBSD_READ: begin
                if (!read_active) begin
                    next_state = HBSD_IDLE;
                end
            end
            HBSD_WRITE: begin
                if (!write_active) begin
                    next_state = HBSD_IDLE;
                end
            end
            default: begin
                next_state = HBSD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            cycle_state <= HBSD_IDLE;
        end else begin
            cycle_state <= next_state;
        end
    end

    // read request: one pulse on entry to a read cycle
    always_ff @(posedge clock) begin
        if (!nrst) begin
            req.read_req <= 1'h0;
        end else begin
            req.read_req <= (cycle_state == HBSD_IDLE) && read_active;
        end
    end

    // write commit: one pulse on the trailing edge of the write strobe
    always_ff @(posedge clock) begin
        if (!nrst) begin
            req.write_req <= 1'h0;
        end else begin
            req.write_req <= (cycle_state == HBSD_WRITE) && !write_active;
        end
    end

    // index is taken at the start of a read, and tracked through a write
    // so that the value stored is the one seen just before the trailing edge
    always_ff @(posedge clock) begin
        if (!nrst) begin
            req.index      <= INDEX_RESET;
            req.write_data <= DATA_RESET;
        end else if (next_state == HBSD_WRITE) begin
            req.index      <= pins_sync.register_index;
            req.write_data <= pins_sync.host_data_in;
        end else if ((cycle_state == HBSD_IDLE) && read_active) begin
            req.index      <= pins_sync.register_index;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            read_pending <= 1'h0;
        end else begin
            read_pending <= req.read_req;
        end
    end

    // the register file answers in the same cycle as the read pulse
    always_ff @(posedge clock) begin
        if (!nrst) begin
            host_data_out <= DATA_RESET;
        end else if (req.read_req) begin
            host_data_out <= reg_read_data;
        end
    end

    // bus is driven only inside a read cycle; turn-off lags the strobe by
    // the synchroniser delay plus one register, a limitation of sampling async strobes
    always_ff @(posedge clock) begin
        if (!nrst) begin
            host_data_oe <= 1'h0;
        end else begin
            host_data_oe <= (next_state == HBSD_READ) && (cycle_state == HBSD_READ) && !req.read_req;
        end
    end

endmodule : hbsd_decode
`default_nettype wire

// *** test/hbsd_decode_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module hbsd_decode_props import hbsd_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // host side
    input wire hbsd_pins_type pins,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe,
    // register side
    input wire hbsd_req_type req,
    input wire logic [7:0] reg_read_data,
    input wire hbsd_state_type cycle_state
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    logic sel;
    logic go;
    assign sel = pins.select_a_high & pins.select_b_high & !pins.select_c_low;
    assign go = cycle_state != HBSD_IDLE;
    a_req_excl: assert property (!(req.read_req && req.write_req)) else $error("both requests");
    a_rd_pulse: assert property (req.read_req |=> !req.read_req) else $error("long read");
    a_wr_pulse: assert property (req.write_req |=> !req.write_req) else $error("long write");
    // byte lands one cycle after the pulse, the drive enable one cycle later still
    a_rd_drive: assert property (req.read_req |=> host_data_out == $past(reg_read_data) ##1
        (host_data_oe || cycle_state != HBSD_READ)) else $error("read byte");
    a_wr_quiet: assert property (cycle_state == HBSD_WRITE |-> !host_data_oe) else $error("drive in write");
    a_sel_gate: assert property ($rose(go) |-> $past(sel, 3)) else $error("unselected");
    a_dir_line: assert property ($rose(go) && $past(pins.bus_style_select, 3) |->
        (cycle_state == HBSD_READ) == $past(pins.write_strobe_low, 3)) else $error("direction");
    a_wr_end: assert property (req.write_req |-> !go && $past(cycle_state) == HBSD_WRITE) else $error("commit");
    c_read: cover property (req.read_req);
    c_write: cover property (req.write_req);
    c_drive: cover property (host_data_oe);
endmodule : hbsd_decode_props
bind hbsd_decode hbsd_decode_props u_props (.clock(clock), .nrst(nrst), .pins(pins), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .req(req), .reg_read_data(reg_read_data), .cycle_state(cycle_state));
`default_nettype wire

// *** test/hbsd_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module hbsd_host import hbsd_pkg::*; (
    // bench side
    input wire logic clock,
    // device drive of the data bus
    input wire logic [7:0] dout,
    input wire logic oe,
    // pins toward the device
    output hbsd_pins_type pins
);
    hbsd_pins_type p = PINS_RESET;
    logic [7:0] d = 8'hA5;
    logic [7:0] q;
    // the pin struct is 19 bits: 11 control and index bits above the data byte
    assign pins = {p[18:8], oe ? dout : d};
    task automatic acc(input logic st, en, wr, hi, input logic [2:0] ix, input logic [7:0] dt, input int n);
        @(negedge clock);
        p.bus_style_select = st;
        p.register_index = ix;
        p.select_a_high = 1'h1;
        p.select_b_high = 1'h1;
        p.select_c_low = !en;
        p.read_strobe_low = !st & (wr | hi);
        p.read_strobe_high = !st & !wr & hi;
        p.write_strobe_low = st ? !wr : !(wr & !hi);
        p.write_strobe_high = !st & wr & hi;
        d = wr ? dt : ~d;
        repeat (n) @(negedge clock);
        q = pins[7:0];
        p = PINS_RESET;
        // released bus must not keep the old byte
        d = ~d;
        repeat (6) @(negedge clock);
    endtask : acc
endmodule : hbsd_host
`default_nettype wire

// *** test/hbsd_decode_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module hbsd_decode_tb;
    import hbsd_pkg::*;
    logic clock = 0;
    logic nrst = 0;
    hbsd_pins_type pins;
    logic [7:0] dout, rrd, mem [8];
    logic oe;
    logic [10:0] wl;
    hbsd_req_type req;
    hbsd_state_type cs;
    int wc = 0, rc = 0, bad_count = 0, comparisons = 0;
    always #25 clock = ~clock;
    // bench stands in for the register file
    assign rrd = mem[req.index];
    always @(posedge clock) begin
        if (req.write_req === 1'h1) begin
            mem[req.index] <= req.write_data;
            wl <= {req.index, req.write_data};
            wc <= wc + 1;
        end
        if (req.read_req === 1'h1) rc <= rc + 1;
    end
    hbsd_host h (.clock(clock), .dout(dout), .oe(oe), .pins(pins));
    hbsd_decode uut (.clock(clock), .nrst(nrst), .pins(pins), .host_data_out(dout), .host_data_oe(oe),
        .req(req), .reg_read_data(rrd), .cycle_state(cs));
    task automatic chk(input string n, input logic [15:0] e, g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wr_rd(input logic st, en, hi, input logic [2:0] ix, input logic [7:0] dt);
        logic [7:0] w0;
        logic [7:0] r0;
        w0 = 8'(wc + en);
        r0 = 8'(rc);
        h.acc(st, en, 1'h1, hi, ix, dt, 3);
        chk("counts", {w0, r0}, {8'(wc), 8'(rc)});
        if (en) chk("wdata", 16'({ix, dt}), 16'(wl));
        h.acc(st, en, 1'h0, hi, ix, 8'h00, 12);
        chk("counts", {w0, 8'(r0 + en)}, {8'(wc), 8'(rc)});
        if (en) chk("rdata", 16'(dt), 16'(h.q));
        chk("state", 16'(HBSD_IDLE), 16'(cs));
        chk("oe", 16'h0000, 16'(oe));
    endtask : wr_rd
    task automatic stop_test;
        $display("compared %0d mismatched %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (16) @(negedge clock);
        nrst = 1;
        for (int i = 0; i < 2; i++) wr_rd(STYLE_SPLIT, 1'h1, i[0], 3'(5 + i), 8'h3C ^ 8'(i));
        $display("done split");
        wr_rd(STYLE_SINGLE, 1'h1, 1'h0, 3'h2, 8'hA5);
        $display("done single");
        wr_rd(STYLE_SPLIT, 1'h0, 1'h0, 3'h7, 8'hFF);
        $display("done nosel");
        stop_test();
    end
    initial begin
        repeat (3000) @(posedge clock);
        bad_count++;
        stop_test();
    end
endmodule : hbsd_decode_tb
`default_nettype wire
